/* scpi_cmd_block.sv */
/*
  status groups, system settings and trigger control of a measuring
  instrument, reached by software over an apb slave.
  assumes: one clock sys_clk, synchronous active-high srst, the command
  parser sits in software and turns each command into a register access.
*/
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "scpi_cmd_defs.svh"

module scpi_cmd_block
#(
  parameter int OPER_W    = 16,
  parameter int ERR_DEPTH = 8
)
(
  input  wire logic                    sys_clk,
  input  wire logic                    srst,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [11:0]             paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic [OPER_W-1:0]       oper_cond_in,
  input  wire logic                    bus_trig_in,
  input  wire logic                    ext_trig_in,
  input  wire logic                    int_trig_in,
  input  wire logic                    man_key_in,
  output logic                         beep_ff,
  output logic                         front_panel_lock_ff,
  output logic                         measure_ff,
  output logic                         oper_summary_ff,
  output logic                         ques_summary_ff,
  output logic                         seq_single_ff,
  output logic                         seq_cont_ff,
  output scpi_cmd_pkg::trig_src_e      trig_src_ff,
  output scpi_cmd_pkg::arm_src_e       arm_src_ff
);
  import scpi_cmd_pkg::*;

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  logic              acc;
  logic              wr;
  logic              rd;
  logic              mapped;
  logic [31:0]       nxt_prdata;
  logic              acc_done_ff;

  // one wait state: answer in the cycle after the first access cycle
  assign acc = psel & penable & ~acc_done_ff;
  assign wr  = acc & pwrite & mapped;
  assign rd  = acc & ~pwrite & mapped;

  // ------------------------------------------------------------------
  // stored settings
  // ------------------------------------------------------------------
  logic [OPER_W-1:0] oper_cond_ff;
  logic [OPER_W-1:0] oper_event_ff;
  logic [OPER_W-1:0] oper_enable_ff;
  logic [OPER_W-1:0] ques_enable_ff;
  logic              beeper_off_ff;
  logic              line_60_ff;
  logic [8:0]        trig_count_ff;
  logic [19:0]       trig_delay_ff;
  logic              stat_preset;
  logic              sys_preset;
  logic              cmd_wr;

  assign cmd_wr      = wr & (paddr == `A_COMMAND);
  assign stat_preset = cmd_wr & pwdata[`CMD_STAT_PRESET];
  assign sys_preset  = cmd_wr & pwdata[`CMD_SYS_PRESET];

  // ------------------------------------------------------------------
  // error queue
  // ------------------------------------------------------------------
  localparam int PW = $clog2(ERR_DEPTH);
  logic [31:0]       err_mem [ERR_DEPTH];
  logic [PW-1:0]     err_rd_ff;
  logic [PW-1:0]     err_wr_ff;
  logic [PW:0]       err_cnt_ff;
  logic              err_push;
  logic              err_pop;

  // push from firmware side; full queue drops new entries
  assign err_push = wr & (paddr == `A_ERR_PUSH)
                  & (err_cnt_ff != (PW+1)'(ERR_DEPTH));
  assign err_pop  = rd & (paddr == `A_ERR_POP) & (err_cnt_ff != '0);

  // queue storage and pointers
  always_ff @(posedge sys_clk)
  begin
    if (err_push)
      err_mem[err_wr_ff] <= pwdata;
    if (srst | sys_preset)
    begin
      err_rd_ff  <= '0;
      err_wr_ff  <= '0;
      err_cnt_ff <= '0;
    end
    else
    begin
      if (err_push)
        err_wr_ff <= err_wr_ff + PW'(1);
      if (err_pop)
        err_rd_ff <= err_rd_ff + PW'(1);
      err_cnt_ff <= err_cnt_ff + (PW+1)'(err_push) - (PW+1)'(err_pop);
    end
  end

  // ------------------------------------------------------------------
  // operation status group
  // ------------------------------------------------------------------
  logic [OPER_W-1:0] rise;

  assign rise = oper_cond_in & ~oper_cond_ff;

  // condition sampled every cycle; reads never touch it
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      oper_cond_ff <= '0;
    else
      oper_cond_ff <= oper_cond_in;
  end

  // event bits: a rising edge wins over the clearing read or a preset
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      oper_event_ff <= '0;
    else if (stat_preset | sys_preset | (rd & (paddr == `A_OPER_EVENT)))
      oper_event_ff <= rise;
    else
      oper_event_ff <= oper_event_ff | rise;
  end

  // enable registers of both groups
  always_ff @(posedge sys_clk)
  begin
    if (srst | stat_preset | sys_preset)
    begin
      oper_enable_ff <= '0;
      ques_enable_ff <= '0;
    end
    else
    begin
      if (wr & (paddr == `A_OPER_ENABLE))
        oper_enable_ff <= pwdata[OPER_W-1:0];
      if (wr & (paddr == `A_QUES_ENABLE))
        ques_enable_ff <= pwdata[OPER_W-1:0];
    end
  end

  // group summaries; questionable event is always zero so never set
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      oper_summary_ff <= 1'b0;
      ques_summary_ff <= 1'b0;
    end
    else
    begin
      oper_summary_ff <= |(oper_event_ff & oper_enable_ff);
      ques_summary_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // system settings
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst | sys_preset)
    begin
      beeper_off_ff       <= 1'b0;
      front_panel_lock_ff <= 1'b0;
      line_60_ff          <= 1'b0;
    end
    else if (wr & (paddr == `A_SYS_CTRL))
    begin
      beeper_off_ff       <= pwdata[`SYS_BEEP_OFF];
      front_panel_lock_ff <= ~pwdata[`SYS_KEYS_FREE];
      line_60_ff          <= pwdata[`SYS_LINE_60];
    end
  end

  // beeper pulse, muted while the beeper is off
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      beep_ff <= 1'b0;
    else
      beep_ff <= cmd_wr & pwdata[`CMD_BEEP_NOW] & ~beeper_off_ff;
  end

  // ------------------------------------------------------------------
  // trigger count and delay
  // ------------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (srst | sys_preset)
    begin
      trig_count_ff <= `RST_TRIG_COUNT;
      trig_delay_ff <= `RST_TRIG_DELAY;
    end
    else
    begin
      // out-of-range counts are refused and keep the old value
      if (wr & (paddr == `A_TRIG_COUNT) & (pwdata[31:9] == '0)
          & (pwdata[8:0] >= `MIN_TRIG_COUNT)
          & (pwdata[8:0] <= `MAX_TRIG_COUNT))
        trig_count_ff <= pwdata[8:0];
      if (wr & (paddr == `A_TRIG_DELAY))
        trig_delay_ff <= pwdata[19:0];
    end
  end

  // ------------------------------------------------------------------
  // trigger and arm source with automatic correction
  // ------------------------------------------------------------------
  logic              src_wr;
  logic              arm_wr;
  trig_src_e         new_src;

  assign src_wr  = wr & (paddr == `A_TRIG_SRC) & (pwdata[2:0] <= 3'h4);
  assign arm_wr  = wr & (paddr == `A_ARM_SRC);
  assign new_src = trig_src_e'(pwdata[2:0]);

  always_ff @(posedge sys_clk)
  begin
    if (srst | sys_preset)
    begin
      trig_src_ff <= TRIG_INT;
      arm_src_ff  <= ARM_IMM;
    end
    else if (src_wr)
    begin
      trig_src_ff <= new_src;
      if ((new_src == TRIG_TIM) & (arm_src_ff == ARM_IMM))
        arm_src_ff <= ARM_BUS;
      else if ((new_src != TRIG_TIM) & (new_src != TRIG_INT)
               & (arm_src_ff != ARM_IMM))
        arm_src_ff <= ARM_IMM;
    end
    else if (arm_wr)
      arm_src_ff <= arm_src_e'(pwdata[1:0]);
  end

  // ------------------------------------------------------------------
  // measurement start and sequence mode
  // ------------------------------------------------------------------
  logic              src_hit;
  logic              arm_hit;

  always_comb
  begin
    unique case (trig_src_ff)
      TRIG_BUS: src_hit = bus_trig_in;
      TRIG_EXT: src_hit = ext_trig_in;
      TRIG_INT: src_hit = int_trig_in;
      TRIG_MAN: src_hit = man_key_in;
      default:  src_hit = 1'b0;
    endcase
    unique case (arm_src_ff)
      ARM_BUS: arm_hit = bus_trig_in;
      ARM_EXT: arm_hit = ext_trig_in;
      ARM_MAN: arm_hit = man_key_in;
      default: arm_hit = 1'b0;
    endcase
  end

  // arm immediate means no sequence, the source fires directly
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      measure_ff    <= 1'b0;
      seq_single_ff <= 1'b0;
      seq_cont_ff   <= 1'b0;
    end
    else
    begin
      measure_ff <= (cmd_wr & pwdata[`CMD_TRIG_NOW])
                  | ((arm_src_ff == ARM_IMM) & src_hit)
                  | ((arm_src_ff != ARM_IMM) & arm_hit);
      seq_single_ff <= (arm_src_ff != ARM_IMM)
                     & (trig_src_ff == TRIG_INT);
      seq_cont_ff   <= (arm_src_ff != ARM_IMM)
                     & (trig_src_ff == TRIG_TIM);
    end
  end

  // ------------------------------------------------------------------
  // read mux and apb answer
  // ------------------------------------------------------------------
  always_comb
  begin
    mapped     = 1'b1;
    nxt_prdata = '0;
    unique case (paddr)
      `A_OPER_COND:   nxt_prdata[OPER_W-1:0] = oper_cond_ff;
      `A_OPER_EVENT:  nxt_prdata[OPER_W-1:0] = oper_event_ff;
      `A_OPER_ENABLE: nxt_prdata[OPER_W-1:0] = oper_enable_ff;
      `A_QUES_COND:   nxt_prdata = '0;
      `A_QUES_EVENT:  nxt_prdata = '0;
      `A_QUES_ENABLE: nxt_prdata[OPER_W-1:0] = ques_enable_ff;
      `A_COMMAND:     nxt_prdata = '0;
      `A_SYS_CTRL:    nxt_prdata[2:0] = {line_60_ff, ~front_panel_lock_ff,
                                         beeper_off_ff};
      `A_ERR_PUSH:    nxt_prdata[PW:0] = err_cnt_ff;
      `A_ERR_POP:     nxt_prdata = (err_cnt_ff != '0) ?
                                   err_mem[err_rd_ff] : '0;
      `A_VERSION:     nxt_prdata[19:0] = {`VER_YEAR, `VER_REV};
      `A_TRIG_COUNT:  nxt_prdata[8:0] = trig_count_ff;
      `A_TRIG_DELAY:  nxt_prdata[19:0] = trig_delay_ff;
      `A_TRIG_SRC:    nxt_prdata[2:0] = trig_src_ff;
      `A_ARM_SRC:     nxt_prdata[1:0] = arm_src_ff;
      `A_SUMMARY:     nxt_prdata[1:0] = {ques_summary_ff, oper_summary_ff};
      default:        mapped = 1'b0;
    endcase
  end

  // data registered so prdata comes straight from a flip-flop
  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      prdata      <= '0;
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      acc_done_ff <= 1'b0;
    end
    else
    begin
      pready      <= acc;
      pslverr     <= acc & ~mapped;
      acc_done_ff <= acc;
      if (acc & ~pwrite)
        prdata <= mapped ? nxt_prdata : '0;
    end
  end
endmodule

/* scpi_cmd_defs.svh */
/*
  register offsets, field positions, reset values and limits of the
  status / system / trigger command block.
  assumes: included by bare name from the design, checker and bench files.
*/
`ifndef SCPI_CMD_DEFS_SVH
`define SCPI_CMD_DEFS_SVH

// ------------------------------------------------------------------
// register byte addresses (apb, one aligned word each)
// ------------------------------------------------------------------
`define A_OPER_COND   12'h000
`define A_OPER_EVENT  12'h004
`define A_OPER_ENABLE 12'h008
`define A_QUES_COND   12'h00c
`define A_QUES_EVENT  12'h010
`define A_QUES_ENABLE 12'h014
`define A_COMMAND     12'h018
`define A_SYS_CTRL    12'h01c
`define A_ERR_PUSH    12'h020
`define A_ERR_POP     12'h024
`define A_VERSION     12'h028
`define A_TRIG_COUNT  12'h02c
`define A_TRIG_DELAY  12'h030
`define A_TRIG_SRC    12'h034
`define A_ARM_SRC     12'h038
`define A_SUMMARY     12'h03c

// ------------------------------------------------------------------
// command strobe bits (write-one pulses)
// ------------------------------------------------------------------
`define CMD_STAT_PRESET 0
`define CMD_BEEP_NOW    1
`define CMD_SYS_PRESET  2
`define CMD_TRIG_NOW    3

// ------------------------------------------------------------------
// system control bits
// ------------------------------------------------------------------
`define SYS_BEEP_OFF    0
`define SYS_KEYS_FREE   1
`define SYS_LINE_60     2

// ------------------------------------------------------------------
// reset values and limits
// ------------------------------------------------------------------
`define RST_TRIG_COUNT  9'h001
`define RST_TRIG_DELAY  20'h00000
`define MIN_TRIG_COUNT  9'h001
`define MAX_TRIG_COUNT  9'h1f4
`define VER_YEAR        16'h07cf
`define VER_REV         4'h0
`define LINE_50_HZ      8'h32
`define LINE_60_HZ      8'h3c

`endif

/* scpi_cmd_pkg.sv */
/*
  types shared by the command block: trigger and arm source codes.
  assumes: nothing beyond the defs header.
*/
package scpi_cmd_pkg;
  typedef enum logic [2:0]
  {
    TRIG_BUS = 3'h0,
    TRIG_EXT = 3'h1,
    TRIG_INT = 3'h2,
    TRIG_MAN = 3'h3,
    TRIG_TIM = 3'h4
  } trig_src_e;

  typedef enum logic [1:0]
  {
    ARM_IMM = 2'h0,
    ARM_BUS = 2'h1,
    ARM_EXT = 2'h2,
    ARM_MAN = 2'h3
  } arm_src_e;
endpackage

/* scpi_cmd_block_checker.sv */
/* checker of the status/system/trigger block ports.
   assumes: bound to scpi_cmd_block, one clock, synchronous srst. */
`timescale 1ns/10ps
`include "scpi_cmd_defs.svh"
module scpi_cmd_block_checker
  import scpi_cmd_pkg::*;
#(
  parameter int OPER_W = 16
)
(
  input wire logic              sys_clk,
  input wire logic              srst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [11:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              ext_trig_in,
  input wire logic              measure_ff,
  input wire logic              ques_summary_ff,
  input wire logic              seq_single_ff,
  input wire logic              seq_cont_ff,
  input wire scpi_cmd_pkg::trig_src_e trig_src_ff,
  input wire scpi_cmd_pkg::arm_src_e  arm_src_ff
);
  // ------------------------------------------------------------
  // access phase decode
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  logic acc;
  logic first;
  // first = access cycle where the write acts, acc = completing edge
  assign acc   = psel && penable && pready;
  assign first = psel && penable && !pready;

  AST_ONE_WAIT: assert property (first |=> pready ##1 !pready)
    else $error("pready not one cycle after access");
  AST_QCOND_ZERO: assert property (acc && !pwrite &&
    paddr == `A_QUES_COND |-> prdata == 32'h0)
    else $error("questionable condition not zero");
  AST_QEVT_ZERO: assert property (acc && !pwrite &&
    paddr == `A_QUES_EVENT |-> prdata == 32'h0)
    else $error("questionable event not zero");
  AST_QSUM_LOW: assert property (!ques_summary_ff)
    else $error("questionable summary raised");
  AST_TRIG_NOW: assert property (acc && pwrite &&
    paddr == `A_COMMAND && pwdata[`CMD_TRIG_NOW] |-> ##[0:1] measure_ff)
    else $error("immediate trigger gave no measurement");
  AST_SRC_LEGAL: assert property (trig_src_ff <= TRIG_TIM)
    else $error("trigger source code out of range");
  AST_TIM_ARM: assert property (first && pwrite &&
    paddr == `A_TRIG_SRC && pwdata[2:0] == 3'h4 && arm_src_ff == ARM_IMM
    |=> arm_src_ff == ARM_BUS)
    else $error("timer source did not move arm to bus");
  AST_IMM_ARM: assert property (first && pwrite &&
    paddr == `A_TRIG_SRC && pwdata[2:0] inside {3'h0, 3'h1, 3'h3} &&
    arm_src_ff != ARM_IMM |=> arm_src_ff == ARM_IMM)
    else $error("source did not move arm to immediate");
  AST_EXT_MEAS: assert property (arm_src_ff == ARM_IMM &&
    trig_src_ff == TRIG_EXT && ext_trig_in |=> measure_ff)
    else $error("external trigger gave no measurement");
  AST_SEQ_ONE: assert property (!(seq_single_ff && seq_cont_ff))
    else $error("single and continuous both set");
endmodule

bind scpi_cmd_block scpi_cmd_block_checker #(.OPER_W(OPER_W)) chk_i
(
  .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .ext_trig_in(ext_trig_in), .measure_ff(measure_ff),
  .ques_summary_ff(ques_summary_ff), .seq_single_ff(seq_single_ff),
  .seq_cont_ff(seq_cont_ff), .trig_src_ff(trig_src_ff),
  .arm_src_ff(arm_src_ff)
);

/* apb_ctrl_model.sv */
/* remote controller model: one apb transfer per go pulse.
   assumes: single sys_clk, synchronous srst, go only while idle. */
`timescale 1ns/10ps
module apb_ctrl_model
(
  input  wire logic        sys_clk,
  input  wire logic        srst,
  input  wire logic        go,
  input  wire logic        wr,
  input  wire logic [11:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic             done,
  output logic      [32:0] rd
);
  initial {psel, penable, pwrite, paddr, pwdata, done, rd} = '0;
  // ------------------------------------------------------------
  // transfer sequencer
  // ------------------------------------------------------------
  // request held until pready; address and data inverted once released
  always @(posedge sys_clk)
  begin
    done <= 1'b0;
    if (srst)
      {psel, penable} <= 2'b00;
    else if (psel && penable && pready)
    begin
      {psel, penable} <= 2'b00;
      paddr  <= ~paddr;
      pwdata <= ~pwdata;
      done   <= 1'b1;
      rd     <= {pslverr, prdata};
    end
    else if (psel)
      penable <= 1'b1;
    else if (go)
    begin
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= addr;
      pwdata <= wdata;
    end
  end
endmodule

/* status_system_trigger_cmds_tb.sv */
/* self-checking bench of the command block over apb.
   assumes: design, checker and controller model compiled before. */
`timescale 1ns/10ps
`include "scpi_cmd_defs.svh"
module status_system_trigger_cmds_tb;
  import scpi_cmd_pkg::*;
  typedef struct { logic [11:0] a; logic [32:0] e; } note_s;
  logic sys_clk = 1'b0, srst = 1'b1, go = 1'b0, wr = 1'b0;
  logic [11:0] addr = '0, paddr;
  logic [31:0] wdata = '0, pwdata, prdata;
  logic [15:0] oper_cond = '0, r, e;
  logic [3:0]  trg = '0;
  logic [32:0] rd;
  logic psel, penable, pwrite, pready, pslverr, done, beep_ff, lock_ff;
  logic measure_ff, oper_sum, ques_sum, seq_single_ff, seq_cont_ff;
  trig_src_e trig_src_ff;
  arm_src_e  arm_src_ff;
  note_s q[$];
  note_s x;
  int n_mismatch = 0, n_tests = 0, n_meas = 0, n_beep = 0, m, ea;
  logic [31:0] w1, w2;

  always #4 sys_clk = ~sys_clk;

  scpi_cmd_block dut
  (
    .sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .oper_cond_in(oper_cond),
    .bus_trig_in(trg[0]), .ext_trig_in(trg[1]), .int_trig_in(trg[2]),
    .man_key_in(trg[3]), .beep_ff(beep_ff), .front_panel_lock_ff(lock_ff),
    .measure_ff(measure_ff), .oper_summary_ff(oper_sum),
    .ques_summary_ff(ques_sum), .seq_single_ff(seq_single_ff),
    .seq_cont_ff(seq_cont_ff), .trig_src_ff(trig_src_ff),
    .arm_src_ff(arm_src_ff)
  );
  apb_ctrl_model ctl
  (
    .sys_clk(sys_clk), .srst(srst), .go(go), .wr(wr), .addr(addr),
    .wdata(wdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .done(done), .rd(rd)
  );

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [32:0] ex,
                     input logic [32:0] got);
    n_tests++;
    if (got !== ex)
    begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic summarize;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for the controller to finish one transfer
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
    int k = 0;
    go <= 1'b1;
    wr <= w;
    addr <= a;
    wdata <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    do @(posedge sys_clk); while (done !== 1'b1 && ++k < 50);
    if (k >= 50)
      chk("transfer done", 1, 0);
  endtask
  task automatic wr32(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd32(input logic [11:0] a, input logic [31:0] d,
                      input logic err = 1'b0);
    q.push_back('{a, {err, d}});
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic pulse(input int s);
    trg <= 4'b1 << s;
    @(posedge sys_clk);
    trg <= 4'h0;
    repeat (3) @(posedge sys_clk);
  endtask

  // ------------------------------------------------------------
  // output watcher: oldest note against each read result
  // ------------------------------------------------------------
  always @(posedge sys_clk)
  begin
    if (measure_ff === 1'b1)
      n_meas++;
    if (beep_ff === 1'b1)
      n_beep++;
    if (done === 1'b1 && pwrite === 1'b0 && q.size() > 0)
    begin
      x = q.pop_front();
      chk($sformatf("reg %h", x.a), x.e, rd);
    end
  end

  initial
  begin
    #40000;
    n_mismatch++;
    summarize();
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    void'($urandom(46));
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    rd32(`A_TRIG_SRC, 32'h2);
    rd32(`A_ARM_SRC, 32'h0);
    rd32(`A_TRIG_COUNT, 32'h1);
    rd32(`A_VERSION, {12'h0, `VER_YEAR, `VER_REV});
    r = 16'($urandom) | 16'h1;
    e = 16'($urandom) | 16'h1;
    oper_cond <= r;
    repeat (2) @(posedge sys_clk);
    rd32(`A_OPER_COND, r);
    rd32(`A_OPER_COND, r);
    rd32(`A_OPER_EVENT, r);
    rd32(`A_OPER_EVENT, 32'h0);
    wr32(`A_OPER_ENABLE, e);
    rd32(`A_OPER_ENABLE, e);
    wr32(`A_QUES_ENABLE, {16'h0, ~e});
    rd32(`A_QUES_ENABLE, {16'h0, ~e});
    rd32(`A_QUES_COND, 32'h0);
    rd32(`A_QUES_EVENT, 32'h0);
    oper_cond <= '0;
    @(posedge sys_clk);
    oper_cond <= r;
    repeat (2) @(posedge sys_clk);
    rd32(`A_SUMMARY, 32'h1);
    chk("oper summary", 33'h1, 33'(oper_sum));
    chk("ques summary", 33'h0, 33'(ques_sum));
    wr32(`A_COMMAND, 32'h1);
    rd32(`A_OPER_ENABLE, 32'h0);
    rd32(`A_QUES_ENABLE, 32'h0);
    rd32(`A_OPER_EVENT, 32'h0);
    rd32(`A_SUMMARY, 32'h0);
    chk("oper summary", 33'h0, 33'(oper_sum));
    for (int v = 0; v < 8; v++)
    begin
      wr32(`A_SYS_CTRL, 32'(v));
      rd32(`A_SYS_CTRL, 32'(v));
      chk("key lock", 33'(v[1] == 0), 33'(lock_ff));
    end
    m = n_beep;
    wr32(`A_COMMAND, 32'h2);
    chk("muted beep", 33'(m), 33'(n_beep));
    wr32(`A_SYS_CTRL, 32'h0);
    wr32(`A_COMMAND, 32'h2);
    chk("beep", 33'(m + 1), 33'(n_beep));
    w1 = $urandom;
    w2 = $urandom;
    wr32(`A_ERR_PUSH, w1);
    wr32(`A_ERR_PUSH, w2);
    rd32(`A_ERR_PUSH, 32'h2);
    rd32(`A_ERR_POP, w1);
    rd32(`A_ERR_POP, w2);
    wr32(`A_TRIG_COUNT, 32'd500);
    rd32(`A_TRIG_COUNT, 32'd500);
    wr32(`A_TRIG_COUNT, 32'd501);
    wr32(`A_TRIG_COUNT, 32'd0);
    rd32(`A_TRIG_COUNT, 32'd500);
    w1 = {12'h0, 20'($urandom)};
    wr32(`A_TRIG_DELAY, w1);
    rd32(`A_TRIG_DELAY, w1);
    for (int s = 0; s < 5; s++)
      for (int a = 0; a < 4; a++)
      begin
        wr32(`A_ARM_SRC, 32'(a));
        wr32(`A_TRIG_SRC, 32'(s));
        ea = (s == 4 && a == 0) ? 1 : (s != 2 && s != 4 && a != 0) ? 0 : a;
        rd32(`A_ARM_SRC, 32'(ea));
        rd32(`A_TRIG_SRC, 32'(s));
        chk("arm port", 33'(ea), 33'(arm_src_ff));
        chk("source port", 33'(s), 33'(trig_src_ff));
      end
    wr32(`A_TRIG_SRC, 32'h5);
    rd32(`A_TRIG_SRC, 32'h4);
    for (int s = 0; s < 4; s++)
    begin
      wr32(`A_ARM_SRC, 32'h0);
      wr32(`A_TRIG_SRC, 32'(s));
      m = n_meas;
      pulse((s + 1) % 4);
      pulse(s);
      chk("source measure", 33'(m + 1), 33'(n_meas));
    end
    m = n_meas;
    wr32(`A_COMMAND, 32'h8);
    repeat (2) @(posedge sys_clk);
    chk("trigger now", 33'(m + 1), 33'(n_meas));
    wr32(`A_ARM_SRC, 32'h1);
    wr32(`A_TRIG_SRC, 32'h2);
    chk("single", 33'h1, 33'(seq_single_ff));
    pulse(0);
    chk("armed measure", 33'(m + 2), 33'(n_meas));
    wr32(`A_TRIG_SRC, 32'h4);
    chk("continuous", 33'h1, 33'(seq_cont_ff));
    wr32(`A_COMMAND, 32'h4);
    rd32(`A_TRIG_COUNT, 32'h1);
    rd32(`A_TRIG_SRC, 32'h2);
    rd32(`A_ARM_SRC, 32'h0);
    rd32(`A_TRIG_DELAY, 32'h0);
    rd32(`A_ERR_PUSH, 32'h0);
    rd32(`A_SYS_CTRL, 32'h2);
    chk("lock after preset", 33'h0, 33'(lock_ff));
    rd32(12'h040, 32'h0, 1'b1);
    repeat (4) @(posedge sys_clk);
    chk("pending reads", 33'h0, 33'(q.size()));
    summarize();
  end
endmodule
